// ==== rtl/bus_phase_timer.sv ====
// bus_phase_timer: emits one pulse per bus clock half period.
// assumes run is low while the bus is idle, and hold marks a stretched clock.
`timescale 1ns/1ps
`default_nettype none
module bus_phase_timer
    import two_wire_pkg::*;
#(
    parameter int CNT_W = 20
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic hold,
    input wire logic [3:0] lin,
    input wire logic [3:0] expo,
    // phase strobe
    output logic phase_tick
);

    logic [7:0] acc_q;
    logic ref_tick;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] half_len;

    // half period in 24 MHz ticks equals one full period in 12 MHz ticks
    assign half_len = CNT_W'({1'b0, lin} + 5'h01) << expo;

    // fractional accumulator gives a 24 MHz tick from 125 MHz
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= 8'h00;
            ref_tick <= 1'b0;
        end
        else if (acc_q + ACC_STEP >= ACC_WRAP)
        begin
            acc_q <= acc_q + ACC_STEP - ACC_WRAP;
            ref_tick <= 1'b1;
        end
        else
        begin
            acc_q <= acc_q + ACC_STEP;
            ref_tick <= 1'b0;
        end
    end

    // phase counter freezes while a slave stretches the clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            phase_tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
            phase_tick <= 1'b0;
        end
        else if (ref_tick && !hold)
        begin
            if (cnt_q >= half_len - CNT_W'(1))
            begin
                cnt_q <= '0;
                phase_tick <= 1'b1;
            end
            else
            begin
                cnt_q <= cnt_q + CNT_W'(1);
                phase_tick <= 1'b0;
            end
        end
        else
        begin
            phase_tick <= 1'b0;
        end
    end

endmodule // bus_phase_timer
`default_nettype wire

// ==== rtl/two_wire_master_controller.sv ====
// two_wire_master_controller: segment driven two-wire bus master.
// assumes software issues one segment at a time and bus lines are pulled up.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - active only when mode select equals three
// - master only, no arbitration
// - bus rate is 12 MHz over divider product
// - slave clock stretching stalls the transfer
// - open-drain drive, lines read back
// - start and stop bits self-clear, flag set
// - send shifts byte, samples ack, flags
// - receive shifts byte in, flags, data readable
// - ack select chooses ack or nack after receive
// - slave nack recorded after transmit
// - one shared data register both ways
// - events on rising finished flags
// - event on transmitted byte with nack
// - overrun and underrun events
// - irq gated by unit and top enables; event pulses are not
// - status flags clear on next activity
// - stop bit makes stop, then self-clears
module two_wire_master_controller
    import two_wire_pkg::*;
#(
    parameter int CNT_W = 20
)
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration
    input wire logic [1:0] serial_mode_select,
    input wire logic [3:0] clock_linear_divider,
    input wire logic [3:0] clock_exponent_divider,
    input wire logic receive_ack_select,
    // segment command write
    input wire logic cmd_write,
    input wire logic [3:0] cmd_wdata,
    output logic [3:0] segment_command_register,
    // shared data register
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    input wire logic data_read,
    output logic [7:0] serial_data_register,
    // status flags
    output logic command_finished_flag,
    output logic transmit_finished_flag,
    output logic receive_finished_flag,
    output logic slave_nack_flag,
    // events and interrupt request
    input wire logic [EV_COUNT-1:0] unit_interrupt_enable,
    input wire logic unit_top_interrupt_bit,
    output logic [EV_COUNT-1:0] event_pulse,
    output logic irq,
    // bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START_REL,
        ST_START_HIGH,
        ST_START_FALL,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_STOP_LOW,
        ST_STOP_HIGH,
        ST_STOP_REL
    } state_e;

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    // asserts at once, releases after two edges
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************************************
    // declarations and decode
    // ****************************************************************
    state_e state_q;
    logic [3:0] cmd_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic tx_loaded_q;
    logic rx_unread_q;
    logic active;
    logic one_hot;
    logic go;
    logic fin;
    logic phase_tick;
    logic hold;
    logic sda_next;
    logic [EV_COUNT-1:0] ev_d;

    assign active = (serial_mode_select == MODE_TWO_WIRE);
    assign one_hot = (cmd_wdata != CMD_NONE) && ((cmd_wdata & (cmd_wdata - 4'h1)) == 4'h0);
    assign go = (state_q == ST_IDLE) && active && (cmd_q != CMD_NONE);
    assign fin = phase_tick && ((state_q == ST_START_FALL) || (state_q == ST_STOP_REL) ||
                 ((state_q == ST_BIT_HIGH) && (bit_cnt_q == BITS_PER_BYTE)));
    // a released clock that still reads low is a stretching slave
    assign hold = !scl_oe && !scl_in;
    // ack slot: transmit releases, receive drives ack when selected
    assign sda_next = (bit_cnt_q == BITS_PER_BYTE) ?
                      (cmd_q[CMD_RECV_BIT] && receive_ack_select) :
                      (cmd_q[CMD_SEND_BIT] && !shift_q[7]);

    bus_phase_timer #(
        .CNT_W(CNT_W)
    ) u_phase (
        .clock(clock),
        .rst_n(rst_n),
        .run(state_q != ST_IDLE),
        .hold(hold),
        .lin(clock_linear_divider),
        .expo(clock_exponent_divider),
        .phase_tick(phase_tick)
    );

    // ****************************************************************
    // segment command register
    // ****************************************************************
    // writes while busy or with several bits set are dropped
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cmd_q <= CMD_RESET;
        else if (!active)
            cmd_q <= CMD_RESET;
        else if (fin)
            cmd_q <= CMD_RESET;
        else if (cmd_write && (cmd_q == CMD_NONE) && one_hot)
            cmd_q <= cmd_wdata;
    end
    assign segment_command_register = cmd_q;

    // ****************************************************************
    // bus sequencer
    // ****************************************************************
    // master only: the line levels are never compared for arbitration
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            bit_cnt_q <= 4'h0;
            shift_q <= DATA_RESET;
        end
        else if (!active)
        begin
            state_q <= ST_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (go && cmd_q[CMD_START_BIT])
                    begin
                        sda_oe <= 1'b0;
                        state_q <= ST_START_REL;
                    end
                    else if (go && cmd_q[CMD_STOP_BIT])
                    begin
                        scl_oe <= 1'b1;
                        state_q <= ST_STOP_LOW;
                    end
                    else if (go)
                    begin
                        scl_oe <= 1'b1;
                        bit_cnt_q <= 4'h0;
                        shift_q <= serial_data_register;
                        state_q <= ST_BIT_LOW;
                    end
                end
                ST_START_REL:
                    if (phase_tick)
                    begin
                        scl_oe <= 1'b0;
                        state_q <= ST_START_HIGH;
                    end
                ST_START_HIGH:
                    if (phase_tick)
                    begin
                        sda_oe <= 1'b1;
                        state_q <= ST_START_FALL;
                    end
                ST_START_FALL:
                    if (phase_tick)
                    begin
                        scl_oe <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                ST_BIT_LOW:
                begin
                    // data moves a cycle after the clock went low
                    sda_oe <= sda_next;
                    if (phase_tick)
                    begin
                        scl_oe <= 1'b0;
                        state_q <= ST_BIT_HIGH;
                    end
                end
                ST_BIT_HIGH:
                    if (phase_tick)
                    begin
                        scl_oe <= 1'b1;
                        if (bit_cnt_q == BITS_PER_BYTE)
                            state_q <= ST_IDLE;
                        else
                        begin
                            shift_q <= {shift_q[6:0], sda_in};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            state_q <= ST_BIT_LOW;
                        end
                    end
                ST_STOP_LOW:
                begin
                    sda_oe <= 1'b1;
                    if (phase_tick)
                    begin
                        scl_oe <= 1'b0;
                        state_q <= ST_STOP_HIGH;
                    end
                end
                ST_STOP_HIGH:
                    if (phase_tick)
                    begin
                        sda_oe <= 1'b0;
                        state_q <= ST_STOP_REL;
                    end
                ST_STOP_REL:
                    if (phase_tick)
                        state_q <= ST_IDLE;
            endcase
        end
    end

    // open drain: only ever pull low, the oe decides the level
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // ****************************************************************
    // shared data register
    // ****************************************************************
    // a received byte is dropped while the last one is still unread
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_data_register <= DATA_RESET;
            tx_loaded_q <= 1'b0;
            rx_unread_q <= 1'b0;
        end
        else
        begin
            if (fin && cmd_q[CMD_RECV_BIT] && !rx_unread_q)
                serial_data_register <= shift_q;
            else if (data_write)
                serial_data_register <= data_wdata;
            if (data_write)
                tx_loaded_q <= 1'b1;
            else if (go && cmd_q[CMD_SEND_BIT])
                tx_loaded_q <= 1'b0;
            if (fin && cmd_q[CMD_RECV_BIT])
                rx_unread_q <= 1'b1;
            else if (data_read)
                rx_unread_q <= 1'b0;
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // set at segment end, cleared when the next segment begins
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            command_finished_flag <= 1'b0;
            transmit_finished_flag <= 1'b0;
            receive_finished_flag <= 1'b0;
            slave_nack_flag <= 1'b0;
        end
        else if (go)
        begin
            command_finished_flag <= 1'b0;
            transmit_finished_flag <= 1'b0;
            receive_finished_flag <= 1'b0;
            slave_nack_flag <= 1'b0;
        end
        else if (fin)
        begin
            if (cmd_q[CMD_START_BIT] || cmd_q[CMD_STOP_BIT])
                command_finished_flag <= 1'b1;
            if (cmd_q[CMD_SEND_BIT])
            begin
                transmit_finished_flag <= 1'b1;
                slave_nack_flag <= sda_in;
            end
            if (cmd_q[CMD_RECV_BIT])
                receive_finished_flag <= 1'b1;
        end
    end

    // ****************************************************************
    // events and interrupt request
    // ****************************************************************
    // flags only rise at fin after go cleared them, so fin is the edge
    always_comb
    begin
        ev_d = '0;
        ev_d[EV_CMD_FIN] = fin && (cmd_q[CMD_START_BIT] || cmd_q[CMD_STOP_BIT]);
        ev_d[EV_TX_FIN] = fin && cmd_q[CMD_SEND_BIT];
        ev_d[EV_RX_FIN] = fin && cmd_q[CMD_RECV_BIT];
        ev_d[EV_NACK] = fin && cmd_q[CMD_SEND_BIT] && sda_in;
        ev_d[EV_RX_OVERRUN] = fin && cmd_q[CMD_RECV_BIT] && rx_unread_q;
        ev_d[EV_TX_UNDERRUN] = go && cmd_q[CMD_SEND_BIT] && !tx_loaded_q;
    end

    // one-cycle pulses; the request needs both enable levels
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_pulse <= '0;
            irq <= 1'b0;
        end
        else
        begin
            event_pulse <= ev_d;
            irq <= unit_top_interrupt_bit && |(ev_d & unit_interrupt_enable);
        end
    end

endmodule // two_wire_master_controller
`default_nettype wire

// ==== shared/two_wire_pkg.sv ====
// two_wire_pkg: constants shared by the two-wire master controller files.
// assumes a 125 MHz system clock and a 12 MHz bus reference derived from it.
package two_wire_pkg;

    // ****************************************************************
    // mode and command encoding
    // ****************************************************************
    localparam logic [1:0] MODE_TWO_WIRE = 2'h3;
    localparam int CMD_RECV_BIT = 0;
    localparam int CMD_SEND_BIT = 1;
    localparam int CMD_START_BIT = 2;
    localparam int CMD_STOP_BIT = 3;
    localparam logic [3:0] CMD_NONE = 4'h0;

    // ****************************************************************
    // event vector layout
    // ****************************************************************
    localparam int EV_CMD_FIN = 0;
    localparam int EV_TX_FIN = 1;
    localparam int EV_RX_FIN = 2;
    localparam int EV_NACK = 3;
    localparam int EV_RX_OVERRUN = 4;
    localparam int EV_TX_UNDERRUN = 5;
    localparam int EV_COUNT = 6;

    // ****************************************************************
    // clocking: the phase clock runs at twice the bus reference
    // ****************************************************************
    localparam int SYS_CLOCK_MHZ = 125;
    localparam int REF_CLOCK_MHZ = 12;
    localparam logic [7:0] ACC_STEP = 8'(2 * REF_CLOCK_MHZ);
    localparam logic [7:0] ACC_WRAP = 8'(SYS_CLOCK_MHZ);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] CMD_RESET = 4'h0;

endpackage : two_wire_pkg

// ==== verif/bus_slave_model.sv ====
// bus_slave_model: behavioural two-wire slave on pulled-up lines.
// assumes the bench builds the wires and steers direction per segment.
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model
(
    // clock
    input wire logic clock,
    // wire levels
    input wire logic scl,
    input wire logic sda,
    // behaviour from the bench
    input wire logic give_nack,
    input wire logic read_mode,
    input wire logic stretch,
    input wire logic [7:0] tx_byte,
    // pulls and observations
    output logic scl_low,
    output logic sda_low,
    output logic [7:0] rx_byte,
    output logic ack_seen
);
    logic [3:0] bit_q = 4'hF;
    logic [7:0] hold_q = 8'h00;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;

    // bit slots advance on clock falls; a start rearms the count
    always @(posedge clock)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda)
            bit_q <= 4'hF;
        else if (scl_q && !scl)
            bit_q <= (bit_q == 4'h8 || bit_q == 4'hF) ? 4'h0 : bit_q + 4'h1;
        if (!scl_q && scl && bit_q < 4'h8)
            rx_byte <= {rx_byte[6:0], sda};
        if (!scl_q && scl && bit_q == 4'h8)
            ack_seen <= sda;
        // long hold so the stall outlasts the master's own low phase
        if (scl_q && !scl && stretch)
            hold_q <= 8'hFF;
        else if (hold_q != 8'h00)
            hold_q <= hold_q - 8'h01;
    end

    // data changes just after a fall, so it is steady while clock is high
    assign scl_low = hold_q != 8'h00;
    assign sda_low = (bit_q == 4'h8 && !read_mode && !give_nack)
        || (read_mode && bit_q < 4'h8 && !tx_byte[~bit_q[2:0]]);
endmodule // bus_slave_model
`default_nettype wire

// ==== verif/two_wire_chk.sv ====
// two_wire_chk: port level assertions for the two-wire master controller.
// assumes scl_in and sda_in are the wired-AND of both parties.
`timescale 1ns/1ps
`default_nettype none
module two_wire_chk
    import two_wire_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control side
    input wire logic [1:0] serial_mode_select,
    input wire logic cmd_write,
    input wire logic [3:0] cmd_wdata,
    input wire logic [3:0] segment_command_register,
    input wire logic command_finished_flag,
    input wire logic transmit_finished_flag,
    input wire logic receive_finished_flag,
    input wire logic slave_nack_flag,
    input wire logic [EV_COUNT-1:0] unit_interrupt_enable,
    input wire logic unit_top_interrupt_bit,
    input wire logic [EV_COUNT-1:0] event_pulse,
    input wire logic irq,
    // bus side
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // ****************
    // helper logic
    // ****************
    logic [3:0] rise_q;
    logic scl_prev_q;
    logic [3:0] cmd;
    assign cmd = segment_command_register;

    // counts scl rises inside a segment; idle gaps restart it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rise_q <= 4'h0;
            scl_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_in;
            if (cmd == CMD_NONE)
                rise_q <= 4'h0;
            else if (scl_in && !scl_prev_q)
                rise_q <= rise_q + 4'h1;
        end
    end

    // ****************
    // assertions
    // ****************
    open_drain_a: assert property (!scl_out && !sda_out)
        else $error("bus output data not held low");
    mode_gate_a: assert property ((serial_mode_select != MODE_TWO_WIRE)[*2]
        |-> cmd == CMD_NONE && !scl_oe && !sda_oe) else $error("active outside two-wire mode");
    cmd_take_a: assert property (cmd_write && serial_mode_select == MODE_TWO_WIRE
        && cmd == CMD_NONE && $onehot(cmd_wdata) |=> cmd == $past(cmd_wdata))
        else $error("legal segment write not taken");
    cmd_refuse_a: assert property (cmd_write && !$onehot(cmd_wdata) && cmd == CMD_NONE
        |=> cmd == CMD_NONE) else $error("illegal segment write taken");
    flag_clear_a: assert property ($rose(cmd != CMD_NONE) |=> !command_finished_flag
        && !transmit_finished_flag && !receive_finished_flag && !slave_nack_flag)
        else $error("status flag kept at new activity");
    tx_event_a: assert property (event_pulse[EV_TX_FIN] == $rose(transmit_finished_flag))
        else $error("transmit event not tied to flag rise");
    cmd_event_a: assert property ($rose(command_finished_flag)
        |-> event_pulse[EV_CMD_FIN] && cmd == CMD_NONE) else $error("command finish event lost");
    nack_event_a: assert property (event_pulse[EV_NACK]
        |-> slave_nack_flag && transmit_finished_flag) else $error("nack event without nack");
    irq_gate_a: assert property ($stable(unit_interrupt_enable) && $stable(unit_top_interrupt_bit)
        |-> irq == (unit_top_interrupt_bit && |(event_pulse & unit_interrupt_enable)))
        else $error("interrupt gating wrong");
    stretch_hold_a: assert property (cmd != CMD_NONE && !scl_oe && !$past(scl_oe) && !scl_in
        |=> !scl_oe) else $error("clock pulled while stretched");
    data_hold_a: assert property ((cmd[CMD_SEND_BIT] || cmd[CMD_RECV_BIT]) && scl_in
        && $past(scl_in) |-> $stable(sda_oe)) else $error("data moved while clock high");
    bit_count_a: assert property ($fell(cmd[CMD_SEND_BIT]) || $fell(cmd[CMD_RECV_BIT])
        |-> rise_q == 4'h9) else $error("byte did not take nine clocks");
    stop_done_a: assert property ($fell(cmd[CMD_STOP_BIT])
        |-> scl_in && sda_in && !scl_oe) else $error("stop left a line low");
endmodule // two_wire_chk

bind two_wire_master_controller two_wire_chk two_wire_chk_inst (.clock(clock), .nrst(nrst),
    .serial_mode_select(serial_mode_select), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
    .segment_command_register(segment_command_register),
    .command_finished_flag(command_finished_flag),
    .transmit_finished_flag(transmit_finished_flag),
    .receive_finished_flag(receive_finished_flag), .slave_nack_flag(slave_nack_flag),
    .unit_interrupt_enable(unit_interrupt_enable), .unit_top_interrupt_bit(unit_top_interrupt_bit),
    .event_pulse(event_pulse), .irq(irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ==== verif/two_wire_master_controller_tb.sv ====
// two_wire_master_controller_tb: segment level tests of the two-wire master.
// assumes the slave model and bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_controller_tb;
    import two_wire_pkg::*;
    logic clock = 0, nrst = 0, ack_sel = 0, cmd_write = 0, data_write = 0, data_read = 0;
    logic top_en = 0, give_nack = 0, read_mode = 0, stretch = 0;
    logic [1:0] mode = 2'h3;
    logic [3:0] lin = 4'h0, expo = 4'h0, cmd_wdata = 4'h0, seg_q;
    logic [7:0] data_wdata = 8'h00, tx_byte = 8'h00, data_q, rx_byte;
    logic [5:0] ev_pulse, ev_seen = 6'h00, unit_en = 6'h3F;
    logic cmd_f, tx_f, rx_f, nack_f, irq, scl_oe, sda_oe, scl_low, sda_low, ack_seen;
    wire scl_w = !scl_oe && !scl_low;
    wire sda_w = !sda_oe && !sda_low;
    int miscompares = 0, n_tests = 0, irq_n = 0, cycles = 0, hi_cnt = 0, last_hi = 0;

    two_wire_master_controller two_wire_master_controller_inst (.clock(clock), .nrst(nrst),
        .serial_mode_select(mode), .clock_linear_divider(lin), .clock_exponent_divider(expo),
        .receive_ack_select(ack_sel), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .segment_command_register(seg_q), .data_write(data_write), .data_wdata(data_wdata),
        .data_read(data_read), .serial_data_register(data_q), .command_finished_flag(cmd_f),
        .transmit_finished_flag(tx_f), .receive_finished_flag(rx_f), .slave_nack_flag(nack_f),
        .unit_interrupt_enable(unit_en), .unit_top_interrupt_bit(top_en), .event_pulse(ev_pulse),
        .irq(irq), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
        .sda_oe(sda_oe));
    bus_slave_model bus_slave_model_inst (.clock(clock), .scl(scl_w), .sda(sda_w),
        .give_nack(give_nack), .read_mode(read_mode), .stretch(stretch), .tx_byte(tx_byte),
        .scl_low(scl_low), .sda_low(sda_low), .rx_byte(rx_byte), .ack_seen(ack_seen));

    // 8 ns period, 125 MHz
    always #4 clock = ~clock;

    // ****************
    // monitors and shared tasks
    // ****************
    // gathers events, high time of scl and the run limit
    always @(posedge clock)
    begin
        ev_seen <= (cmd_write ? 6'h00 : ev_seen) | ev_pulse;
        irq_n <= irq_n + (irq === 1'b1);
        hi_cnt <= scl_w ? hi_cnt + 1 : 0;
        if (!scl_w && hi_cnt != 0)
            last_hi <= hi_cnt;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic results();
    begin
        $display("checks=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    // write pulse, then a bounded wait for the bits to clear
    task automatic seg(input logic [3:0] c);
        int n;
    begin
        @(negedge clock);
        cmd_write = 1;
        cmd_wdata = c;
        @(negedge clock);
        cmd_write = 0;
        for (n = 0; n < 8000 && seg_q !== 4'h0; n++)
            @(negedge clock);
        @(negedge clock);
    end
    endtask

    task automatic load(input logic [7:0] d);
    begin
        @(negedge clock);
        data_write = 1;
        data_wdata = d;
        @(negedge clock);
        data_write = 0;
    end
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_refuse();
    begin
        @(negedge clock);
        cmd_write = 1;
        cmd_wdata = 4'h6;
        @(negedge clock);
        cmd_wdata = 4'h0;
        @(negedge clock);
        mode = 2'h1;
        cmd_wdata = 4'h4;
        @(negedge clock);
        @(negedge clock);
        cmd_write = 0;
        mode = 2'h3;
        @(negedge clock);
        check(8'(seg_q), 8'h00);
        check(8'({scl_w, sda_w}), 8'h03);
    end
    endtask

    task automatic t_write();
    begin
        seg(4'h4);
        check(8'({cmd_f, ev_seen[EV_CMD_FIN], irq_n == 0}), 8'h07);
        top_en = 1;
        load(8'hA4);
        check(data_q, 8'hA4);
        seg(4'h2);
        check(rx_byte, 8'hA4);
        check(8'({tx_f, nack_f, ev_seen[EV_TX_UNDERRUN], irq_n > 0}), 8'h09);
        give_nack = 1;
        seg(4'h2);
        check(8'({nack_f, ev_seen[EV_NACK], ev_seen[EV_TX_UNDERRUN]}), 8'h07);
        give_nack = 0;
        seg(4'h8);
        check(8'({cmd_f, tx_f, nack_f, scl_w, sda_w}), 8'h13);
    end
    endtask

    task automatic t_read();
    begin
        unit_en = 6'h00;
        seg(4'h4);
        load(8'hF5);
        seg(4'h2);
        check(rx_byte, 8'hF5);
        read_mode = 1;
        tx_byte = 8'h5A;
        ack_sel = 1;
        seg(4'h1);
        check(data_q, 8'h5A);
        check(8'({rx_f, ack_seen, nack_f, irq_n == 4}), 8'h09);
        ack_sel = 0;
        tx_byte = 8'h3C;
        seg(4'h1);
        check(8'({data_q == 8'h5A, ev_seen[EV_RX_OVERRUN], ack_seen}), 8'h07);
        read_mode = 0;
        data_read = 1;
        @(negedge clock);
        data_read = 0;
        seg(4'h8);
    end
    endtask

    task automatic t_stretch();
        int t0, plain;
    begin
        lin = 4'hF;
        expo = 4'h1;
        seg(4'h4);
        load(8'h81);
        t0 = cycles;
        seg(4'h2);
        plain = cycles - t0;
        // 375 kbps: half period 32 ticks at 24 MHz, near 167 cycles
        check(8'(last_hi > 164 && last_hi < 169), 8'h01);
        stretch = 1;
        load(8'h7E);
        t0 = cycles;
        seg(4'h2);
        check(8'(cycles - t0 > plain + 200), 8'h01);
        check(rx_byte, 8'h7E);
        stretch = 0;
        seg(4'h8);
    end
    endtask

    // six cycles of reset, then the scenarios
    initial
    begin
        repeat (6) @(negedge clock);
        nrst = 1;
        repeat (3) @(negedge clock);
        t_refuse();
        t_write();
        t_read();
        t_stretch();
        results();
    end
endmodule // two_wire_master_controller_tb
`default_nettype wire
